// ===== rtl/ofi_pkg.sv
// Constants, register map and state encoding for the optical front end serial target port.
// Assumes a single 100 MHz core clock; the bus pins arrive asynchronously.
package ofi_pkg;

    localparam int CLK_MHZ = 100;
    localparam int FAST_MODE_KBPS = 400;
    // One bus bit period in core cycles; the pin filters must settle well inside it
    localparam int BIT_CYCLES = (CLK_MHZ * 1000) / FAST_MODE_KBPS;

    localparam int DATA_W = 16;
    localparam int FIFO_DEPTH = 8;

    localparam logic [6:0] DEFAULT_BUS_ADDR = 7'h64;
    localparam logic [7:0] ADDR_UNLOCK_CODE = 8'had;

    localparam logic [7:0] REG_BUS_ADDRESS_CONFIG = 8'h09;
    localparam logic [7:0] REG_ADDRESS_CHANGE_KEY = 8'h0d;
    localparam logic [7:0] REG_SOFTWARE_RESET_CONTROL = 8'h0f;
    localparam logic [7:0] REG_PIN_BUFFER_ENABLE = 8'h4f;
    localparam logic [7:0] REG_FIFO_LEVEL = 8'h5f;
    localparam logic [7:0] REG_FIFO_READ_PORT = 8'h60;
    localparam logic [7:0] REG_NO_INC_LOW = 8'h5f;
    localparam logic [7:0] REG_NO_INC_HIGH = 8'h7f;

    // Field positions
    localparam int CFG_ADDR_LSB = 1;
    localparam int CFG_ADDR_MSB = 7;
    localparam int CFG_CODE_LSB = 8;
    localparam int CFG_CODE_MSB = 15;
    localparam int KEY_USE_INT = 0;
    localparam int KEY_INT_LEVEL = 1;
    localparam int KEY_USE_AUX = 2;
    localparam int KEY_AUX_LEVEL = 3;
    localparam int PINBUF_AUX_EN = 0;
    localparam int PINBUF_INT_EN = 1;
    localparam int SRST_BIT = 0;

    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    typedef enum logic [3:0] {
        OFI_IDLE,
        OFI_ADDR,
        OFI_ADDR_ACK,
        OFI_REG,
        OFI_REG_ACK,
        OFI_WDATA,
        OFI_WACK,
        OFI_RDATA,
        OFI_RACK
    } ofi_state_e_t;

endpackage : ofi_pkg

// ===== rtl/ofi_fifo.sv
// Synchronous word FIFO with valid/ready on both sides and a flush.
// Assumes both sides run on the same clock as the serial target port.
`timescale 1ns/10ps
module ofi_fifo
    import ofi_pkg::*;
#(
    parameter int WIDTH = DATA_W,
    parameter int DEPTH = FIFO_DEPTH
)
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic flush_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [$clog2(DEPTH+1)-1:0] count_o
);

    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [CW-1:0] cnt;
    } ofi_fifo_state_t;

    ofi_fifo_state_t s;
    ofi_fifo_state_t next_s;
    logic push;
    logic pop;

    assign in_ready_o = (s.cnt != CNT_FULL);
    assign out_valid_o = (s.cnt != '0);
    assign out_data_o = s.mem[s.rp];
    assign count_o = s.cnt;

    always_comb
    begin
        next_s = s;
        push = in_valid_i && in_ready_o;
        pop = out_ready_i && out_valid_o;
        if (push)
        begin
            next_s.mem[s.wp] = in_data_i;
            next_s.wp = (s.wp == PTR_LAST) ? '0 : PW'(s.wp + 1'b1);
        end
        if (pop)
        begin
            next_s.rp = (s.rp == PTR_LAST) ? '0 : PW'(s.rp + 1'b1);
        end
        if (push && !pop)
        begin
            next_s.cnt = CW'(s.cnt + 1'b1);
        end
        else if (pop && !push)
        begin
            next_s.cnt = CW'(s.cnt - 1'b1);
        end
        // Flush drops everything, including a word offered in the same cycle
        if (flush_i)
        begin
            next_s.wp = '0;
            next_s.rp = '0;
            next_s.cnt = '0;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

endmodule : ofi_fifo

// ===== rtl/ofi_i2c_target.sv
// Two-wire serial target port of the optical front end: bus address handling,
// keyed address change, word reads with auto-advance, single-word writes, soft reset.
// Assumes SCL, SDA and the strap pins are asynchronous; SDA is open drain and
// resolved outside; the sample stream arrives on the core clock.
//
// Notes on behaviour
// - Acts as a bus target; pins are filtered fast enough for 400 kbps.
// - Registers are reached only through the serial port.
// - After asynchronous reset the target answers at 7-bit address 0x64; soft reset keeps the current address.
// - An accepted address change takes bits 7:1 of the written config word.
// - Key register picks which interrupt and aux select pin levels qualify.
// - New address applies only when the upper config byte is 0xAD.
// - Config write must be the very next register write after the key.
// - Multiword read: host acknowledges until the last byte of the last word.
// - Each word read from the FIFO location pops one entry.
// - Read address advances per word, except at 0x5F, 0x60 and 0x7F.
// - A write carries at most one 16-bit word; extra bytes are refused.
// - Writing soft reset bit 0 resets at once and is not acknowledged.
// - Start, address with direction bit, data, then stop frame each transfer.
`timescale 1ns/10ps
module ofi_i2c_target
    import ofi_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic int_i,
    input wire logic auxiliary_select_pin_i,
    input wire logic data_valid_i,
    input wire logic [DATA_W-1:0] data_i,
    output logic data_ready_o,
    output logic [6:0] bus_address_o,
    output logic soft_reset_o
);

    localparam int CW = $clog2(FIFO_DEPTH+1);

    typedef struct packed {
        ofi_state_e_t st;
        logic [2:0] scl_q;
        logic [2:0] sda_q;
        logic [2:0] int_q;
        logic [2:0] aux_q;
        logic scl_f;
        logic sda_f;
        logic int_f;
        logic aux_f;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic rw;
        logic [7:0] reg_ptr;
        logic [1:0] widx;
        logic [7:0] wmsb;
        logic [15:0] rword;
        logic rhalf;
        logic acked;
        logic oe;
        logic [15:0] bus_cfg;
        logic [15:0] key;
        logic [15:0] pinbuf;
        logic armed;
        logic [6:0] dev_addr;
        logic pop;
        logic srst;
    } ofi_state_t;

    ofi_state_t s;
    ofi_state_t next_s;
    logic fifo_valid;
    logic [DATA_W-1:0] fifo_head;
    logic [CW-1:0] fifo_count;

    // Word returned for a register pointer; unmapped locations read as zero
    function automatic logic [15:0] ofi_read_word(
        input logic [7:0] ptr,
        input ofi_state_t cur,
        input logic hv,
        input logic [DATA_W-1:0] head,
        input logic [CW-1:0] cnt
    );
        logic [15:0] w;
        w = RESET_WORD;
        if (ptr == REG_BUS_ADDRESS_CONFIG)
        begin
            w = cur.bus_cfg;
        end
        else if (ptr == REG_ADDRESS_CHANGE_KEY)
        begin
            w = cur.key;
        end
        else if (ptr == REG_PIN_BUFFER_ENABLE)
        begin
            w = cur.pinbuf;
        end
        else if (ptr == REG_FIFO_LEVEL)
        begin
            w = 16'(cnt);
        end
        else if (ptr == REG_FIFO_READ_PORT)
        begin
            w = hv ? head : RESET_WORD;
        end
        return w;
    endfunction : ofi_read_word

    // Whether the strap pins, as buffered, match the stored key
    function automatic logic ofi_pins_qualify(input ofi_state_t cur);
        logic int_ok;
        logic aux_ok;
        int_ok = !cur.key[KEY_USE_INT]
            || (cur.pinbuf[PINBUF_INT_EN] && (cur.int_f == cur.key[KEY_INT_LEVEL]));
        aux_ok = !cur.key[KEY_USE_AUX]
            || (cur.pinbuf[PINBUF_AUX_EN] && (cur.aux_f == cur.key[KEY_AUX_LEVEL]));
        return int_ok && aux_ok;
    endfunction : ofi_pins_qualify

    // Settled level of one sync chain; a lone glitch on the pin never reaches the state machine
    function automatic logic ofi_settle(input logic [2:0] q, input logic f);
        return (q[1] == q[2]) ? q[2] : f;
    endfunction : ofi_settle

    always_comb
    begin
        logic scl_rise;
        logic scl_fall;
        logic start_c;
        logic stop_c;
        logic [15:0] word;
        logic [15:0] nword;
        logic [7:0] nptr;
        scl_rise = 1'b0;
        scl_fall = 1'b0;
        start_c = 1'b0;
        stop_c = 1'b0;
        word = RESET_WORD;
        nword = RESET_WORD;
        nptr = s.reg_ptr;

        next_s = s;
        next_s.pop = 1'b0;
        next_s.srst = 1'b0;

        // Three-stage sync; a level counts once stages two and three agree
        next_s.scl_q = {s.scl_q[1:0], scl_i};
        next_s.sda_q = {s.sda_q[1:0], sda_i};
        next_s.int_q = {s.int_q[1:0], int_i};
        next_s.aux_q = {s.aux_q[1:0], auxiliary_select_pin_i};
        next_s.scl_f = ofi_settle(s.scl_q, s.scl_f);
        next_s.sda_f = ofi_settle(s.sda_q, s.sda_f);
        next_s.int_f = ofi_settle(s.int_q, s.int_f);
        next_s.aux_f = ofi_settle(s.aux_q, s.aux_f);

        scl_rise = !s.scl_f && next_s.scl_f;
        scl_fall = s.scl_f && !next_s.scl_f;
        start_c = s.scl_f && next_s.scl_f && s.sda_f && !next_s.sda_f;
        stop_c = s.scl_f && next_s.scl_f && !s.sda_f && next_s.sda_f;

        if (stop_c)
        begin
            next_s.st = OFI_IDLE;
            next_s.oe = 1'b0;
        end
        else if (start_c)
        begin
            // Repeated start keeps the register pointer for the read phase
            next_s.st = OFI_ADDR;
            next_s.bitcnt = '0;
            next_s.oe = 1'b0;
        end
        else
        begin
            case (s.st)
                OFI_IDLE:
                begin
                    next_s.oe = 1'b0;
                end
                OFI_ADDR:
                begin
                    if (scl_rise)
                    begin
                        next_s.shreg = {s.shreg[6:0], next_s.sda_f};
                        next_s.bitcnt = 4'(s.bitcnt + 4'h1);
                    end
                    else if (scl_fall && (s.bitcnt == BYTE_BITS))
                    begin
                        if (s.shreg[7:1] == s.dev_addr)
                        begin
                            next_s.rw = s.shreg[0];
                            next_s.oe = 1'b1;
                            next_s.st = OFI_ADDR_ACK;
                        end
                        else
                        begin
                            // Not ours: stay silent until the next start
                            next_s.st = OFI_IDLE;
                        end
                    end
                end
                OFI_ADDR_ACK:
                begin
                    if (scl_fall)
                    begin
                        next_s.bitcnt = '0;
                        if (s.rw)
                        begin
                            nword = ofi_read_word(s.reg_ptr, s, fifo_valid, fifo_head, fifo_count);
                            next_s.rword = nword;
                            next_s.shreg = nword[15:8];
                            next_s.oe = !nword[15];
                            next_s.rhalf = 1'b0;
                            next_s.st = OFI_RDATA;
                        end
                        else
                        begin
                            next_s.oe = 1'b0;
                            next_s.st = OFI_REG;
                        end
                    end
                end
                OFI_REG:
                begin
                    if (scl_rise)
                    begin
                        next_s.shreg = {s.shreg[6:0], next_s.sda_f};
                        next_s.bitcnt = 4'(s.bitcnt + 4'h1);
                    end
                    else if (scl_fall && (s.bitcnt == BYTE_BITS))
                    begin
                        next_s.reg_ptr = s.shreg;
                        next_s.widx = 2'h0;
                        next_s.oe = 1'b1;
                        next_s.st = OFI_REG_ACK;
                    end
                end
                OFI_REG_ACK, OFI_WACK:
                begin
                    if (scl_fall)
                    begin
                        next_s.oe = 1'b0;
                        next_s.bitcnt = '0;
                        next_s.st = OFI_WDATA;
                    end
                end
                OFI_WDATA:
                begin
                    if (scl_rise)
                    begin
                        next_s.shreg = {s.shreg[6:0], next_s.sda_f};
                        next_s.bitcnt = 4'(s.bitcnt + 4'h1);
                    end
                    else if (scl_fall && (s.bitcnt == BYTE_BITS))
                    begin
                        if (s.widx == 2'h0)
                        begin
                            next_s.wmsb = s.shreg;
                            next_s.widx = 2'h1;
                            next_s.oe = 1'b1;
                            next_s.st = OFI_WACK;
                        end
                        else if (s.widx == 2'h1)
                        begin
                            word = {s.wmsb, s.shreg};
                            next_s.widx = 2'h2;
                            next_s.oe = 1'b1;
                            next_s.st = OFI_WACK;
                            // Any write other than the key disarms a pending change
                            next_s.armed = 1'b0;
                            if (s.reg_ptr == REG_BUS_ADDRESS_CONFIG)
                            begin
                                next_s.bus_cfg = word;
                                if (s.armed && (word[CFG_CODE_MSB:CFG_CODE_LSB] == ADDR_UNLOCK_CODE)
                                    && ofi_pins_qualify(s))
                                begin
                                    next_s.dev_addr = word[CFG_ADDR_MSB:CFG_ADDR_LSB];
                                end
                            end
                            else if (s.reg_ptr == REG_ADDRESS_CHANGE_KEY)
                            begin
                                next_s.key = word;
                                next_s.armed = 1'b1;
                            end
                            else if (s.reg_ptr == REG_PIN_BUFFER_ENABLE)
                            begin
                                next_s.pinbuf = word;
                            end
                            else if ((s.reg_ptr == REG_SOFTWARE_RESET_CONTROL) && word[SRST_BIT])
                            begin
                                // Reset is immediate, so the word is left unacknowledged
                                next_s.oe = 1'b0;
                                next_s.srst = 1'b1;
                                next_s.st = OFI_IDLE;
                                next_s.bus_cfg = RESET_WORD;
                                next_s.key = RESET_WORD;
                                next_s.pinbuf = RESET_WORD;
                                next_s.reg_ptr = '0;
                            end
                        end
                        else
                        begin
                            // Only one word per write: further bytes get no acknowledge
                            next_s.oe = 1'b0;
                            next_s.st = OFI_IDLE;
                        end
                    end
                end
                OFI_RDATA:
                begin
                    if (scl_rise)
                    begin
                        next_s.bitcnt = 4'(s.bitcnt + 4'h1);
                    end
                    else if (scl_fall)
                    begin
                        if (s.bitcnt == BYTE_BITS)
                        begin
                            next_s.oe = 1'b0;
                            next_s.st = OFI_RACK;
                        end
                        else
                        begin
                            next_s.shreg = {s.shreg[6:0], 1'b0};
                            next_s.oe = !s.shreg[6];
                        end
                    end
                end
                OFI_RACK:
                begin
                    if (scl_rise)
                    begin
                        next_s.acked = !next_s.sda_f;
                        if (s.rhalf)
                        begin
                            if (s.reg_ptr == REG_FIFO_READ_PORT)
                            begin
                                next_s.pop = fifo_valid;
                            end
                            else if ((s.reg_ptr != REG_NO_INC_LOW) && (s.reg_ptr != REG_NO_INC_HIGH))
                            begin
                                next_s.reg_ptr = 8'(s.reg_ptr + 8'h01);
                            end
                        end
                        if (next_s.sda_f)
                        begin
                            // Host ended the burst; release the line and wait for stop
                            next_s.st = OFI_IDLE;
                        end
                    end
                    else if (scl_fall && s.acked)
                    begin
                        next_s.bitcnt = '0;
                        if (!s.rhalf)
                        begin
                            next_s.shreg = s.rword[7:0];
                            next_s.oe = !s.rword[7];
                            next_s.rhalf = 1'b1;
                        end
                        else
                        begin
                            nptr = s.reg_ptr;
                            nword = ofi_read_word(nptr, s, fifo_valid, fifo_head, fifo_count);
                            next_s.rword = nword;
                            next_s.shreg = nword[15:8];
                            next_s.oe = !nword[15];
                            next_s.rhalf = 1'b0;
                        end
                        next_s.st = OFI_RDATA;
                    end
                end
                default:
                begin
                    next_s.st = OFI_IDLE;
                    next_s.oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            s <= '0;
            s.st <= OFI_IDLE;
            s.scl_q <= 3'h7;
            s.sda_q <= 3'h7;
            s.scl_f <= 1'b1;
            s.sda_f <= 1'b1;
            s.dev_addr <= DEFAULT_BUS_ADDR;
        end
        else
        begin
            s <= next_s;
        end
    end

    // Sample stream into the read-port FIFO; the producer stalls while it is full
    ofi_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .flush_i(s.srst),
        .in_valid_i(data_valid_i),
        .in_ready_o(data_ready_o),
        .in_data_i(data_i),
        .out_valid_o(fifo_valid),
        .out_ready_i(s.pop),
        .out_data_o(fifo_head),
        .count_o(fifo_count)
    );

    // Registers reachable only over the serial pins; SDA can only pull low
    assign sda_o = 1'b0;
    assign sda_oe_o = s.oe;
    assign bus_address_o = s.dev_addr;
    assign soft_reset_o = s.srst;

endmodule : ofi_i2c_target

// ===== sim/ofi_i2c_target_monitor.sv
// Port checker for the serial target port, bound to its top module.
// Assumes one core clock and an active-low asynchronous reset.
`timescale 1ns/10ps
module ofi_i2c_target_monitor
    import ofi_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic scl_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic data_valid_i,
    input wire logic data_ready_o,
    input wire logic [6:0] bus_address_o,
    input wire logic soft_reset_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);
    a_reset_addr: assert property ($rose(arst_n_i) |-> bus_address_o == DEFAULT_BUS_ADDR)
        else $error("address not default");
    a_ready_reset: assert property ($rose(arst_n_i) |-> data_ready_o)
        else $error("buffer not ready");
    a_srst_pulse: assert property (soft_reset_o |-> !sda_oe_o ##1 (!soft_reset_o && !sda_oe_o) [*8])
        else $error("reset pulse too long or acknowledged");
    // A drive change with SCL high would fake a start or stop
    a_oe_scl_low: assert property (!$stable(sda_oe_o) |-> !scl_i)
        else $error("drive moved, clock high");
    a_sda_zero: assert property (sda_o == 1'b0)
        else $error("drive value not low");
    a_ready_fall: assert property ($fell(data_ready_o) |-> $past(data_valid_i))
        else $error("full without push");
    a_oe_hold: assert property ($rose(sda_oe_o) |-> sda_oe_o [*8])
        else $error("drive dropped early");
    a_addr_scl_low: assert property (!$stable(bus_address_o) |-> !scl_i)
        else $error("address moved, clock high");
endmodule : ofi_i2c_target_monitor
bind ofi_i2c_target ofi_i2c_target_monitor mon (.clk_i, .arst_n_i, .scl_i, .sda_o, .sda_oe_o,
    .data_valid_i, .data_ready_o, .bus_address_o, .soft_reset_o);

// ===== sim/ofi_host.sv
// Bus host model: drives SCL and its share of the open-drain data wire.
// Assumes the core clock paces it; SDA has a pull-up.
`timescale 1ns/10ps
module ofi_host
(
    input wire logic clk_i,
    input wire logic dev_oe_i,
    output logic scl_o,
    output logic sda_o
);
    logic pull = 1'b0;
    initial scl_o = 1'b1;
    assign sda_o = !(pull || dev_oe_i);
    // Quarter of a 160 ns bit, just after a core edge
    task automatic q();
        repeat (4) @(posedge clk_i);
        #1;
    endtask : q
    task automatic bx(input logic b, output logic r);
        q();
        pull = !b;
        q();
        scl_o = 1'b1;
        q();
        r = sda_o;
        q();
        scl_o = 1'b0;
    endtask : bx
    task automatic st(input logic again);
        if (again)
        begin
            q();
            pull = 1'b0;
            q();
            scl_o = 1'b1;
        end
        q();
        pull = 1'b1;
        q();
        scl_o = 1'b0;
    endtask : st
    task automatic sp();
        q();
        pull = 1'b1;
        q();
        scl_o = 1'b1;
        q();
        pull = 1'b0;
        q();
    endtask : sp
    // Release level a on the ninth bit: 1 reads the target's answer or ends a read
    task automatic by(input logic [7:0] d, input logic a, output logic [7:0] o, output logic k);
        logic r;
        for (int i = 7; i >= 0; i--)
            bx(d[i], o[i]);
        bx(a, r);
        k = !r;
    endtask : by
endmodule : ofi_host

// ===== sim/test_optical_frontend_i2c_slave_port.sv
// Self-checking bench for the serial target port.
// Assumes the host model paces the bus; the stream is driven here.
`timescale 1ns/10ps
module test_optical_frontend_i2c_slave_port
    import ofi_pkg::*;
;
    typedef struct packed {logic [7:0] r; logic [15:0] w; logic [15:0] e;} ofi_row_t;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic int_i = 1'b0;
    logic aux_i = 1'b0;
    logic valid = 1'b0;
    logic [15:0] data = 16'h0000;
    logic scl, sda, oe, ready, srst;
    logic [6:0] addr;
    logic [6:0] ba = DEFAULT_BUS_ADDR;
    logic [3:0] k;
    logic [15:0] got[$];
    int mismatches = 0;
    int compares = 0;
    int pulses = 0;
    int n;
    ofi_row_t rows[4] = '{'{8'h0d, 16'h1234, 16'h1234}, '{8'h4f, 16'h0003, 16'h0003},
        '{8'h0f, 16'h0000, 16'h0000}, '{8'h33, 16'hbeef, 16'h0000}};
    always #5 clk_i = !clk_i;
    always @(posedge clk_i)
        if (srst === 1'b1)
            pulses++;
    ofi_host h (.clk_i(clk_i), .dev_oe_i(oe), .scl_o(scl), .sda_o(sda));
    ofi_i2c_target dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .scl_i(scl), .sda_i(sda), .sda_o(),
        .sda_oe_o(oe), .int_i(int_i), .auxiliary_select_pin_i(aux_i), .data_valid_i(valid),
        .data_i(data), .data_ready_o(ready), .bus_address_o(addr), .soft_reset_o(srst));
    task automatic report_and_stop();
        if (mismatches == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        compares++;
        if (s !== e)
        begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wr(input logic [6:0] a, input logic [7:0] r, input logic [15:0] d, input logic x);
        logic [7:0] o;
        h.st(1'b0);
        h.by({a, 1'b0}, 1'b1, o, k[3]);
        h.by(r, 1'b1, o, k[2]);
        h.by(d[15:8], 1'b1, o, k[1]);
        h.by(d[7:0], 1'b1, o, k[0]);
        if (x)
            h.by(8'h56, 1'b1, o, k[0]);
        h.sp();
    endtask : wr
    task automatic rd(input logic [7:0] r, input int cnt);
        logic x;
        logic [15:0] w;
        got = {};
        h.st(1'b0);
        h.by({ba, 1'b0}, 1'b1, w[7:0], x);
        h.by(r, 1'b1, w[7:0], x);
        h.st(1'b1);
        h.by({ba, 1'b1}, 1'b1, w[7:0], x);
        for (int i = 0; i < cnt; i++)
        begin
            h.by(8'hff, 1'b0, w[15:8], x);
            h.by(8'hff, i == cnt - 1, w[7:0], x);
            got.push_back(w);
        end
        h.sp();
    endtask : rd
    task automatic ac(input logic p, input logic [15:0] key, input logic brk, input logic [15:0] cfg,
        input logic [6:0] e);
        int_i = p;
        aux_i = p;
        wr(ba, 8'h0d, key, 1'b0);
        if (brk)
            wr(ba, 8'h4f, 16'h0002, 1'b0);
        wr(ba, 8'h09, cfg, 1'b0);
        chk("address", {9'h000, e}, {9'h000, addr});
        ba = e;
    endtask : ac
    initial
    begin
        repeat (3) @(posedge clk_i);
        #1;
        arst_n_i = 1'b1;
        repeat (4) @(posedge clk_i);
        #1;
        foreach (rows[i])
        begin
            wr(ba, rows[i].r, rows[i].w, 1'b0);
            chk("wack", 16'h000f, {12'h000, k});
            rd(rows[i].r, 1);
            chk("read", rows[i].e, got[0]);
        end
        rd(8'h4e, 2);
        chk("advance", 16'h0003, got[1]);
        wr(ba, 8'h0d, 16'h5678, 1'b1);
        chk("extra", 16'h000e, {12'h000, k});
        rd(8'h0d, 1);
        chk("word", 16'h5678, got[0]);
        n = 0;
        valid = 1'b1;
        while (ready === 1'b1 && n < 20)
        begin
            data = 16'h1000 + 16'(n);
            @(posedge clk_i);
            #1;
            n++;
        end
        // Producer keeps offering against a full buffer
        repeat (8) @(posedge clk_i);
        #1;
        valid = 1'b0;
        chk("fill", 16'h0008, 16'(n));
        rd(8'h5f, 2);
        chk("level", 16'h0008, got[1]);
        rd(8'h60, 3);
        foreach (got[i]) chk("pop", 16'h1000 + 16'(i), got[i]);
        rd(8'h60, 5);
        chk("last", 16'h1007, got[4]);
        rd(8'h60, 1);
        chk("empty", 16'h0000, got[0]);
        wr(ba, 8'h4f, 16'h0003, 1'b0);
        ac(1'b0, 16'h0003, 1'b0, 16'had20, 7'h64);
        ac(1'b1, 16'h0003, 1'b0, 16'had20, 7'h10);
        ac(1'b1, 16'h000c, 1'b0, 16'had40, 7'h20);
        ac(1'b1, 16'h0003, 1'b1, 16'had30, 7'h20);
        ac(1'b1, 16'h0003, 1'b0, 16'h0030, 7'h20);
        wr(7'h64, 8'h4f, 16'h0002, 1'b0);
        chk("old", 16'h0000, {15'h0000, k[3]});
        wr(ba, 8'h0f, 16'h0001, 1'b0);
        chk("srst nack", 16'h000e, {12'h000, k});
        chk("srst", 16'h0001, 16'(pulses));
        rd(8'h4f, 1);
        chk("cleared", 16'h0000, got[0]);
        arst_n_i = 1'b0;
        @(posedge clk_i);
        #1;
        arst_n_i = 1'b1;
        chk("rst addr", 16'h0064, {9'h000, addr});
        report_and_stop();
    end
    initial
    begin
        #900000;
        mismatches++;
        report_and_stop();
    end
endmodule : test_optical_frontend_i2c_slave_port
